// File: hw/dch_pkg.sv
// Shared constants and types for the debug command handler.
// Assumes one 200 MHz system clock and byte-wide link and memory ports.
package dch_pkg;

    // ----------------------------------------------------------------
    // Command codes and fixed answers
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_RD_DMEM = 8'h0d;
    localparam logic [7:0] CMD_PM_CRC = 8'h0e;
    localparam logic [7:0] CMD_STEP = 8'h10;
    localparam logic [7:0] CMD_STUFF = 8'h11;
    localparam logic [7:0] CMD_EXEC = 8'h12;
    localparam logic [7:0] BLOCKED_BYTE = 8'hff;
    localparam logic [15:0] BLOCKED_CRC = 16'hffff;

    // ----------------------------------------------------------------
    // Operand counts, sizes and CRC settings
    // ----------------------------------------------------------------
    localparam logic [2:0] RD_OPND_BYTES = 3'h4;
    localparam logic [2:0] STUFF_OPND_BYTES = 3'h1;
    localparam logic [16:0] SIZE_ZERO_COUNT = 17'h10000;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam int PMEM_BYTES_DEF = 65536;
    localparam int FIFO_DEPTH = 4;

    // ----------------------------------------------------------------
    // Instruction byte handed to the processor
    // ----------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] data;
    } dch_exec_t;

    // Handler states, one-hot.
    typedef enum logic [12:0] {
        ST_IDLE = 13'h0001,
        ST_OPND = 13'h0002,
        ST_DREQ = 13'h0004,
        ST_DWAIT = 13'h0008,
        ST_DPUSH = 13'h0010,
        ST_CRC = 13'h0020,
        ST_CRCEND = 13'h0040,
        ST_CRCHI = 13'h0080,
        ST_CRCLO = 13'h0100,
        ST_EXFIRST = 13'h0200,
        ST_EXLEN = 13'h0400,
        ST_EXEC = 13'h0800,
        ST_DISC = 13'h1000
    } dch_state_t;

endpackage : dch_pkg

// File: hw/dch_top.sv
// Debug command handler: memory read, program CRC, step, stuff, execute.
// Assumes link bytes arrive decoded on sys_clk, at least two cycles apart.
//
// Notes on behaviour
// - Command 0dh takes address then size, high bytes first, returns size bytes.
// - A size of zero means 65536 bytes; other sizes are returned exactly.
// - Outside debug mode every data-memory byte reads back as ffh.
// - Command 0eh returns CRC-CCITT over program memory, upper byte first.
// - Outside debug mode the CRC command answers ffffh.
// - The CRC answer comes roughly one clock per program byte later.
// - Command 10h steps one instruction, ignored if not debug or protected.
// - Command 11h takes an opcode byte and stuffs it, same gating.
// - Command 12h streams a 1 to 7 byte instruction to the processor.
// - Blocked 12h swallows exactly one byte and executes nothing.
// - Read-protect bit low blocks code access; high enables everything in debug mode.
`timescale 1ns/1ps
`default_nettype none

module dch_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Filling side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Draining side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    localparam logic [AW:0] FULL_COUNT = (AW+1)'(D);
    localparam logic [AW-1:0] LAST_SLOT = AW'(D - 1);

    logic [W-1:0] mem [D];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;

    wire do_push = in_valid & in_ready;
    wire do_pop = out_valid & out_ready;

    assign in_ready = (count != FULL_COUNT);
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        return (p == LAST_SLOT) ? '0 : p + AW'(1);
    endfunction : bump

    always_ff @(posedge sys_clk)
    begin
        if (do_push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            wr_ptr <= do_push ? bump(wr_ptr) : wr_ptr;
            rd_ptr <= do_pop ? bump(rd_ptr) : rd_ptr;
            count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end

endmodule : dch_fifo

module dch_top #(
    parameter int PMEM_BYTES = dch_pkg::PMEM_BYTES_DEF
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Decoded bytes from the debug serial pin.
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    // Answer bytes towards the debug serial pin.
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [7:0] tx_data,
    // Debugger status.
    input wire logic debug_mode,
    input wire logic read_protect_bit,
    // Data memory read port, data one cycle after the request.
    output logic dmem_req,
    output logic [15:0] dmem_addr,
    input wire logic [7:0] dmem_rdata,
    // Program memory read port, data one cycle after the request.
    output logic pmem_req,
    output logic [15:0] pmem_addr,
    input wire logic [7:0] pmem_rdata,
    // Processor instruction injection.
    output logic cpu_step,
    output logic cpu_stuff,
    output logic [7:0] cpu_opcode,
    input wire logic [2:0] inst_len,
    output var dch_pkg::dch_exec_t cpu_exec
);
    import dch_pkg::*;

    localparam logic [16:0] PM_LAST = 17'(PMEM_BYTES - 1);

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {b, 8'h00};
        for (int i = 0; i < 8; i++)
        begin
            r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        return r;
    endfunction : crc_byte

    dch_state_t state;
    dch_state_t next_state;
    logic [7:0] cmd;
    logic [31:0] opnd;
    logic [2:0] ocnt;
    logic [16:0] left;
    logic [7:0] rbyte;
    logic in_dbg;
    logic [16:0] pm_addr;
    logic pm_pend;
    logic [15:0] crc;
    logic [2:0] ex_cnt;
    logic fifo_in_ready;

    // ----------------------------------------------------------------
    // Decoding
    // ----------------------------------------------------------------
    wire exec_ok = debug_mode & read_protect_bit;
    wire idle_take = (state == ST_IDLE) & rx_valid;
    wire opnd_last = (state == ST_OPND) & rx_valid & (ocnt == 3'h1);
    wire [31:0] opnd_full = {opnd[23:0], rx_data};
    wire [16:0] size_cnt = (opnd_full[15:0] == 16'h0000) ? SIZE_ZERO_COUNT
                                                         : {1'b0, opnd_full[15:0]};
    wire fifo_in_valid = (state == ST_DPUSH) | (state == ST_CRCHI) | (state == ST_CRCLO);
    wire [7:0] fifo_in_data = (state == ST_DPUSH) ? rbyte
                            : (state == ST_CRCHI) ? crc[15:8] : crc[7:0];
    wire pushed = fifo_in_valid & fifo_in_ready;

    // ----------------------------------------------------------------
    // Command sequencing
    // ----------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
            begin
                if (rx_valid)
                begin
                    case (rx_data)
                        CMD_RD_DMEM: next_state = ST_OPND;
                        CMD_STUFF: next_state = ST_OPND;
                        CMD_PM_CRC: next_state = exec_ok ? ST_CRC : ST_CRCHI;
                        CMD_EXEC: next_state = exec_ok ? ST_EXFIRST : ST_DISC;
                        default: next_state = ST_IDLE;
                    endcase
                end
            end
            ST_OPND: next_state = opnd_last ? ((cmd == CMD_RD_DMEM) ? ST_DREQ : ST_IDLE)
                                            : ST_OPND;
            ST_DREQ: next_state = ST_DWAIT;
            ST_DWAIT: next_state = ST_DPUSH;
            ST_DPUSH: next_state = !pushed ? ST_DPUSH
                                 : (left == 17'h00001) ? ST_IDLE : ST_DREQ;
            ST_CRC: next_state = (pm_addr == PM_LAST) ? ST_CRCEND : ST_CRC;
            ST_CRCEND: next_state = ST_CRCHI;
            ST_CRCHI: next_state = pushed ? ST_CRCLO : ST_CRCHI;
            ST_CRCLO: next_state = pushed ? ST_IDLE : ST_CRCLO;
            ST_EXFIRST: next_state = rx_valid ? ST_EXLEN : ST_EXFIRST;
            ST_EXLEN: next_state = (inst_len <= 3'h1) ? ST_IDLE : ST_EXEC;
            ST_EXEC: next_state = (rx_valid && ex_cnt == 3'h1) ? ST_IDLE : ST_EXEC;
            ST_DISC: next_state = rx_valid ? ST_IDLE : ST_DISC;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state <= ST_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------
    // Operand capture and data memory read
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            cmd <= '0;
            opnd <= '0;
            ocnt <= '0;
            in_dbg <= 1'b0;
        end
        else if (idle_take)
        begin
            cmd <= rx_data;
            ocnt <= (rx_data == CMD_RD_DMEM) ? RD_OPND_BYTES : STUFF_OPND_BYTES;
            in_dbg <= debug_mode;
        end
        else if ((state == ST_OPND) && rx_valid)
        begin
            opnd <= opnd_full;
            ocnt <= ocnt - 3'h1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            dmem_addr <= '0;
            left <= '0;
            rbyte <= '0;
        end
        else if (opnd_last)
        begin
            dmem_addr <= opnd_full[31:16];
            left <= size_cnt;
        end
        else if (state == ST_DWAIT)
        begin
            rbyte <= in_dbg ? dmem_rdata : BLOCKED_BYTE;
        end
        else if (pushed && state == ST_DPUSH)
        begin
            dmem_addr <= dmem_addr + 16'h0001;
            left <= left - 17'h00001;
        end
    end

    assign dmem_req = (state == ST_DREQ) & in_dbg;

    // ----------------------------------------------------------------
    // Program memory CRC
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pm_addr <= '0;
            pm_pend <= 1'b0;
            crc <= CRC_INIT;
        end
        else
        begin
            pm_pend <= (state == ST_CRC);
            pm_addr <= (state == ST_CRC) ? pm_addr + 17'h00001 : '0;
            if (idle_take)
            begin
                crc <= exec_ok ? CRC_INIT : BLOCKED_CRC;
            end
            else if (pm_pend)
            begin
                crc <= crc_byte(crc, pmem_rdata);
            end
        end
    end

    assign pmem_req = (state == ST_CRC);
    assign pmem_addr = pm_addr[15:0];

    // ----------------------------------------------------------------
    // Instruction injection
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            cpu_step <= 1'b0;
            cpu_stuff <= 1'b0;
            cpu_opcode <= '0;
            cpu_exec <= '0;
            ex_cnt <= '0;
        end
        else
        begin
            cpu_step <= idle_take & (rx_data == CMD_STEP) & exec_ok;
            cpu_stuff <= opnd_last & (cmd == CMD_STUFF) & exec_ok;
            cpu_exec <= '0;
            if ((opnd_last && cmd == CMD_STUFF) || (state == ST_EXFIRST && rx_valid))
            begin
                cpu_opcode <= rx_data;
            end
            if (state == ST_EXLEN)
            begin
                cpu_exec <= '{valid: 1'b1, last: (inst_len <= 3'h1), data: cpu_opcode};
                ex_cnt <= inst_len - 3'h1;
            end
            else if (state == ST_EXEC && rx_valid)
            begin
                cpu_exec <= '{valid: 1'b1, last: (ex_cnt == 3'h1), data: rx_data};
                ex_cnt <= ex_cnt - 3'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Answer buffer
    // ----------------------------------------------------------------
    dch_fifo #(.W(8), .D(FIFO_DEPTH)) u_tx_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(tx_valid),
        .out_ready(tx_ready),
        .out_data(tx_data)
    );

    // ----------------------------------------------------------------
    // Scan length seen by the checks
    // ----------------------------------------------------------------
    // Counts scan cycles, so that a short scan cannot pass as a finished one.
    logic [16:0] scan_cycles;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            scan_cycles <= '0;
        end
        else
        begin
            scan_cycles <= (state == ST_CRC) ? scan_cycles + 17'h00001
                         : (state == ST_CRCEND) ? scan_cycles : '0;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence crc_hi_sent;
        (state == ST_CRCHI) && fifo_in_ready;
    endsequence

    sequence crc_lo_next;
        (state == ST_CRCLO) && $stable(crc) && (fifo_in_data == crc[7:0]);
    endsequence

    sequence exec_final_byte;
        (state == ST_EXEC) && rx_valid && (ex_cnt == 3'h1);
    endsequence

    rd_last_byte_a: assert property (
        ((state == ST_DPUSH) && pushed && left == 17'h00001) |=> (state == ST_IDLE))
        else $error("read did not end after last byte");
    rd_zero_size_a: assert property (
        (opnd_last && cmd == CMD_RD_DMEM && opnd_full[15:0] == 16'h0000)
        |=> (left == SIZE_ZERO_COUNT))
        else $error("zero size not 65536");
    rd_ff_fill_a: assert property (
        (pushed && state == ST_DPUSH && !in_dbg) |-> (fifo_in_data == BLOCKED_BYTE))
        else $error("blocked read byte not ff");
    crc_order_a: assert property (
        crc_hi_sent |=> crc_lo_next)
        else $error("crc low byte did not follow high");
    crc_blocked_a: assert property (
        (idle_take && rx_data == CMD_PM_CRC && !debug_mode)
        |=> (state == ST_CRCHI) && (crc == BLOCKED_CRC))
        else $error("blocked crc not ffff");
    crc_quiet_a: assert property (
        (state == ST_CRCEND) |-> (scan_cycles == PM_LAST + 17'h00001))
        else $error("crc answered before full scan");
    step_gate_a: assert property (
        cpu_step |-> $past(debug_mode) && $past(read_protect_bit))
        else $error("step while blocked");
    stuff_gate_a: assert property (
        cpu_stuff |-> $past(exec_ok) && (cpu_opcode == $past(rx_data)))
        else $error("stuff gating or opcode wrong");
    exec_last_a: assert property (
        exec_final_byte |=> cpu_exec.valid && cpu_exec.last && (state == ST_IDLE))
        else $error("execute did not end on its last byte");
    exec_discard_a: assert property (
        (idle_take && rx_data == CMD_EXEC && !exec_ok)
        |=> (state == ST_DISC) ##1 (cpu_exec.valid == 1'b0))
        else $error("blocked execute not discarded");
    cmd_opnd_a: assert property (
        (idle_take && rx_data == CMD_RD_DMEM) |=> (state == ST_OPND) && (ocnt == RD_OPND_BYTES))
        else $error("read operands not expected");

endmodule : dch_top

`default_nettype wire

// File: dv/dch_host_model.sv
// Debug host model: drains answer bytes from the block into a queue.
// Assumes one sys_clk domain and a bench that raises stall to hold the link off.
`timescale 1ns/1ps
`default_nettype none

module dch_host_model (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Test control.
    input wire logic stall,
    // Answer bytes from the block.
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready
);
    import dch_pkg::*;
    logic [7:0] got[$];

    // The host waits for answers; a stall leaves the block's buffer to fill.
    always @(negedge sys_clk) tx_ready <= !stall && !rst;

    always @(posedge sys_clk)
    begin
        if (!rst && tx_valid && tx_ready)
        begin
            got.push_back(tx_data);
        end
    end
endmodule : dch_host_model

`default_nettype wire

// File: dv/dch_top_tb.sv
// Self-checking bench for the debug command handler.
// Assumes the host model, behavioural memories and a short program memory.
`timescale 1ns/1ps
`default_nettype none

module dch_top_tb;
    import dch_pkg::*;
    localparam int PMB = 16;
    logic sys_clk = 0, rst = 1, rx_valid = 0, debug_mode = 1, read_protect_bit = 1, stall = 0;
    logic [7:0] rx_data = 8'h00, dmem_rdata = 8'h00, pmem_rdata = 8'h00, dlat = 8'h00;
    logic [7:0] plat = 8'h00, tx_data, cpu_opcode;
    logic [2:0] inst_len = 3'h1;
    logic tx_valid, tx_ready, dmem_req, pmem_req, cpu_step, cpu_stuff;
    logic [15:0] dmem_addr, pmem_addr;
    dch_exec_t cpu_exec;
    int mismatches = 0, comparisons = 0, cyc = 0, steps = 0, stuffs = 0, dreqs = 0;
    logic [8:0] ex_q[$];

    always #2.5 sys_clk = ~sys_clk;

    dch_top #(.PMEM_BYTES(PMB)) dut_u (.sys_clk(sys_clk), .rst(rst), .rx_valid(rx_valid),
        .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
        .debug_mode(debug_mode), .read_protect_bit(read_protect_bit), .dmem_req(dmem_req),
        .dmem_addr(dmem_addr), .dmem_rdata(dmem_rdata), .pmem_req(pmem_req),
        .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata), .cpu_step(cpu_step),
        .cpu_stuff(cpu_stuff), .cpu_opcode(cpu_opcode), .inst_len(inst_len),
        .cpu_exec(cpu_exec));

    dch_host_model host_u (.sys_clk(sys_clk), .rst(rst), .stall(stall), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready));

    // Memories answer one cycle after the request; the processor side is monitored.
    always @(posedge sys_clk)
    begin
        cyc++;
        if (dmem_req) dlat <= ~dmem_addr[7:0];
        if (pmem_req) plat <= 8'(pmem_addr[7:0] * 8'h03 + 8'h01);
        if (!rst && dmem_req) dreqs++;
        if (!rst && cpu_step) steps++;
        if (!rst && cpu_stuff) stuffs++;
        if (!rst && cpu_exec.valid) ex_q.push_back({cpu_exec.last, cpu_exec.data});
        if (cyc == 20000)
        begin
            mismatches++;
            test_done();
        end
    end

    always @(negedge sys_clk)
    begin
        dmem_rdata <= dlat;
        pmem_rdata <= plat;
    end

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e)
        begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task automatic send(input logic [7:0] b);
        @(negedge sys_clk);
        rx_valid = 1'b1;
        rx_data = b;
        @(negedge sys_clk);
        rx_valid = 1'b0;
        @(negedge sys_clk);
    endtask : send

    task automatic pull(output logic [7:0] b);
        int n;
        n = 0;
        while (host_u.got.size() == 0 && n < 400)
        begin
            @(negedge sys_clk);
            n++;
        end
        b = (host_u.got.size() > 0) ? host_u.got.pop_front() : 8'hxx;
    endtask : pull

    function automatic logic [15:0] crc_exp();
        logic [15:0] c;
        logic [7:0] b;
        c = 16'hffff;
        for (int a = 0; a < PMB; a++)
        begin
            b = 8'(a * 3 + 1);
            c = c ^ {b, 8'h00};
            for (int k = 0; k < 8; k++) c = c[15] ? ((c << 1) ^ 16'h1021) : (c << 1);
        end
        return c;
    endfunction : crc_exp

    // Data read, optionally with the host stalled so the buffer fills first.
    task automatic t_read(input logic dbg, input logic [15:0] ad, input logic [15:0] sz,
        input logic stl);
        logic [7:0] b;
        logic [15:0] a;
        debug_mode = dbg;
        stall = stl;
        dreqs = 0;
        send(CMD_RD_DMEM);
        send(ad[15:8]);
        send(ad[7:0]);
        send(sz[15:8]);
        send(sz[7:0]);
        if (stl)
        begin
            repeat (40) @(negedge sys_clk);
            chk(16'(tx_valid), 16'h1);
            chk(16'(dreqs > 5), 16'h0);
            stall = 1'b0;
        end
        for (int i = 0; i < sz; i++)
        begin
            a = ad + 16'(i);
            pull(b);
            chk(b, dbg ? {8'h00, ~a[7:0]} : 16'h00ff);
        end
        repeat (10) @(negedge sys_clk);
        chk(16'(host_u.got.size()), 16'h0);
        chk(16'(dreqs), dbg ? sz : 16'h0000);
    endtask : t_read

    // A zero size streams on; a reset in mid-answer must cut it off cleanly.
    task automatic t_reset();
        logic [7:0] b;
        debug_mode = 1'b1;
        stall = 1'b0;
        send(CMD_RD_DMEM);
        send(8'h00);
        send(8'hf0);
        send(8'h00);
        send(8'h00);
        for (int i = 0; i < 8; i++)
        begin
            pull(b);
            chk(b, {8'h00, ~(8'hf0 + 8'(i))});
        end
        rst = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk(16'({tx_valid, dmem_req, pmem_req}), 16'h0);
        rst = 1'b0;
        host_u.got.delete();
        repeat (20) @(negedge sys_clk);
        chk(16'({tx_valid, dmem_req, cpu_exec.valid}), 16'h0);
        chk(16'(host_u.got.size()), 16'h0);
    endtask : t_reset

    task automatic t_crc(input logic dbg, input logic rp);
        logic [7:0] hi;
        logic [7:0] lo;
        int c0;
        debug_mode = dbg;
        read_protect_bit = rp;
        send(CMD_PM_CRC);
        c0 = cyc;
        pull(hi);
        if (dbg && rp) chk(16'(cyc - c0 >= PMB), 16'h1);
        pull(lo);
        chk({hi, lo}, (dbg && rp) ? crc_exp() : 16'hffff);
    endtask : t_crc

    // Step, stuff and execute under every debug and protection combination.
    task automatic t_gate();
        int s0;
        int f0;
        logic ok;
        for (int m = 0; m < 4; m++)
        begin
            debug_mode = m[0];
            read_protect_bit = m[1];
            ok = m[0] & m[1];
            s0 = steps;
            f0 = stuffs;
            ex_q.delete();
            inst_len = 3'h3;
            send(8'h33);
            send(CMD_STEP);
            send(CMD_STUFF);
            send(8'ha5);
            repeat (3) @(negedge sys_clk);
            chk(16'(steps - s0), 16'(ok));
            chk(16'(stuffs - f0), 16'(ok));
            if (ok) chk(cpu_opcode, 8'ha5);
            send(CMD_EXEC);
            send(8'hc1);
            if (ok)
            begin
                send(8'hc2);
                send(8'hc3);
                inst_len = 3'h1;
                send(CMD_EXEC);
                send(8'h77);
            end
            repeat (4) @(negedge sys_clk);
            chk(16'(ex_q.size()), ok ? 16'h4 : 16'h0);
            if (ok)
            begin
                chk(ex_q[0], 9'h0c1);
                chk(ex_q[1], 9'h0c2);
                chk(ex_q[2], 9'h1c3);
                chk(ex_q[3], 9'h177);
            end
        end
    endtask : t_gate

    task automatic test_done();
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
        begin
            $display("All checks passed");
        end
        else
        begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done

    initial
    begin
        repeat (12) @(negedge sys_clk);
        rst = 1'b0;
        t_read(1'b1, 16'h1234, 16'h0006, 1'b1);
        t_read(1'b0, 16'h12fe, 16'h0003, 1'b0);
        t_reset();
        t_crc(1'b1, 1'b1);
        t_crc(1'b0, 1'b1);
        t_crc(1'b1, 1'b0);
        t_gate();
        test_done();
    end
endmodule : dch_top_tb

`default_nettype wire
